//--- dv/sml_host_model.sv
// Host-side model issuing task-file commands
`timescale 1ns/1ns
module sml_host_model
  import sml_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Task-file strobe
  output logic cmd_valid,
  output sml_pkg::sml_taskfile_s cmd_tf
);
  initial begin
    cmd_valid = 1'b0;
    cmd_tf = '0;
  end
  task automatic put(input sml_taskfile_s tf);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_tf <= tf;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_tf <= ~tf;
  endtask
  task automatic send(input sml_taskfile_s tf, input logic native);
    sml_taskfile_s n;
    n = tf;
    n.command = CMD_READ_NATIVE;
    if (native) put(n);
    put(tf);
  endtask
endmodule // sml_host_model

//--- dv/sml_limit_chk_assertions.sv
// Port assertions for the address-limit interpreter
`timescale 1ns/1ns
module sml_limit_chk
  import sml_pkg::*;
#(
  parameter logic DRIVE_ID = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Requests
  input wire logic cmd_valid,
  input wire sml_pkg::sml_taskfile_s cmd_tf,
  input wire logic acc_valid,
  input wire logic [27:0] acc_lba,
  input wire sml_pkg::sml_wb_req_s wb_req,
  // Answers
  input wire sml_pkg::sml_result_s cmd_result,
  input wire logic cmd_done,
  input wire logic acc_abort,
  input wire logic [27:0] limit_out,
  input wire sml_pkg::sml_sub_e sub_cmd,
  input wire logic sub_valid,
  input wire logic wb_ack
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire f9 = cmd_valid && cmd_tf.command == CMD_SET_LIMIT
            && cmd_tf.device[DEV_DRV_BIT] == DRIVE_ID;
  wire abort_error_flag = cmd_done && cmd_result.error[ERR_ABT_BIT];
  done_timing_a: assert property (f9 |=> cmd_done)
    else $error("no done after command");
  done_cause_a: assert property (cmd_done |-> $past(f9))
    else $error("done without command");
  range_abort_a: assert property (acc_valid && acc_lba > limit_out
    |=> acc_abort || $changed(limit_out)) else $error("access beyond limit passed");
  range_pass_a: assert property (acc_valid && acc_lba <= limit_out
    |=> !acc_abort || $changed(limit_out)) else $error("access within limit refused");
  abort_flags_a: assert property (abort_error_flag |-> cmd_result.status[ST_ERR_BIT] &&
    cmd_result.status[ST_RDY_BIT] && !cmd_result.status[ST_BSY_BIT]) else $error("bad status");
  abort_keep_a: assert property (abort_error_flag |=> $stable(limit_out))
    else $error("limit moved on abort");
  ack_timing_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack too long");
  sub_kind_a: assert property (sub_valid |-> sub_cmd != SML_SUB_NONE)
    else $error("subcommand without kind");
endmodule // sml_limit_chk

bind sml_limit_cmd sml_limit_chk #(.DRIVE_ID(DRIVE_ID)) u_chk (.sys_clk, .rst_b, .cmd_valid,
  .cmd_tf, .acc_valid,
  .acc_lba, .wb_req, .cmd_result, .cmd_done, .acc_abort, .limit_out, .sub_cmd, .sub_valid,
  .wb_ack);

//--- dv/tb.sv
// Self-checking bench for the address-limit interpreter
`timescale 1ns/1ns
`define CHK(n, e, g) chk(n, (g) === (e), 32'(e), 32'(g))
module tb;
  import sml_pkg::*;
  localparam logic [27:0] NAT = 28'h0ff_ffff;
  logic sys_clk, rst_b, hard_reset_b, acc_valid, offset_mode, ext_hpa_set, cmd_valid, sv;
  logic cmd_done, acc_abort, sub_valid, wb_ack, irq;
  logic [27:0] acc_lba, limit_out, lim;
  logic [31:0] wb_dat_o, q, rnd;
  sml_taskfile_s cmd_tf;
  sml_result_s cmd_result;
  sml_sub_e sub_cmd, sc;
  sml_wb_req_s wb_req;
  int err_count, checks;
  sml_host_model host (.sys_clk, .cmd_valid, .cmd_tf);
  sml_limit_cmd #(.NATIVE_MAX(NAT)) dut (.sys_clk, .rst_b, .hard_reset_b, .cmd_valid, .cmd_tf,
    .acc_valid, .acc_lba, .offset_mode, .ext_hpa_set, .cmd_result, .cmd_done, .acc_abort,
    .limit_out, .sub_cmd, .sub_valid, .wb_req, .wb_dat_o, .wb_ack, .irq);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic ok, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (!ok) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_for(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (s !== 1'b1 && n < 20);
    if (s !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_req <= {1'b1, 1'b1, we, 4'hf, a, d};
    wait_for(wb_ack);
    q = wb_dat_o;
    wb_req <= '0;
  endtask
  // Sends one limit command, read-native first when nat is set
  task automatic cmd(input logic nat, lba, nv, input logic [27:0] a, input logic [7:0] f);
    host.send({f, 7'h00, nv, a[7:0], a[15:8], a[23:16], 1'b1, lba, 1'b1, 1'b0, a[27:24],
      CMD_SET_LIMIT}, nat);
    wait_for(cmd_done);
    sv = sub_valid;
    sc = sub_cmd;
    @(posedge sys_clk);
  endtask
  task automatic acc(input logic [27:0] a, input logic e);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_lba <= a;
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    acc_lba <= ~a;
    @(posedge sys_clk);
    `CHK("acc_abort", e, acc_abort);
  endtask
  task automatic hrst();
    hard_reset_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    hard_reset_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  initial begin
    rst_b = 1'b0;
    hard_reset_b = 1'b1;
    acc_valid = 1'b0;
    acc_lba = '0;
    offset_mode = 1'b0;
    ext_hpa_set = 1'b0;
    wb_req = '0;
    rnd = 32'h0000_510a;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    `CHK("limit_rst", 28'hfff_ffff, limit_out);
    wb(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, q);
    wb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    wb(1'b0, REG_IRQ_MASK, 32'h0000_0000);
    `CHK("mask", 32'h0000_0001, q);
    repeat (4) begin
      rnd = lfsr(rnd);
      lim = 28'(rnd[27:0] % NAT);
      cmd(1'b1, 1'b1, 1'b0, lim, rnd[31:24]);
      `CHK("abt", 1'b0, cmd_result.error[ERR_ABT_BIT]);
      `CHK("limit", lim, limit_out);
      wb(1'b0, REG_ID60, 32'h0000_0000);
      `CHK("id60", {4'h0, lim}, q);
      wb(1'b0, REG_ID100, 32'h0000_0000);
      `CHK("id100", {4'h0, lim}, q);
      acc(lim, 1'b0);
      acc(lim + 28'h000_0001, 1'b1);
    end
    `CHK("irq", 1'b1, irq);
    wb(1'b1, REG_IRQ_STAT, 32'h0000_000f);
    repeat (2) @(posedge sys_clk);
    `CHK("irq_clr", 1'b0, irq);
    // Cylinder 2 with 15 heads of 64 sectors
    cmd(1'b1, 1'b0, 1'b0, 28'h000_0200, 8'h00);
    `CHK("chs", 28'h000_0b3f, limit_out);
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    wb(1'b0, REG_LIMIT, 32'h0000_0000);
    `CHK("sw_drop", {4'h0, NAT}, q);
    cmd(1'b1, 1'b1, 1'b1, 28'h001_2345, 8'h00);
    hrst();
    `CHK("nv_keep", 28'h001_2345, limit_out);
    cmd(1'b1, 1'b1, 1'b0, 28'h000_1000, 8'h00);
    hrst();
    `CHK("vol_lost", NAT, limit_out);
    offset_mode <= 1'b1;
    cmd(1'b1, 1'b1, 1'b1, 28'h000_0100, 8'h00);
    `CHK("offset_abt", 1'b1, cmd_result.error[ERR_ABT_BIT]);
    `CHK("abt_status", 8'h41, cmd_result.status);
    offset_mode <= 1'b0;
    ext_hpa_set <= 1'b1;
    cmd(1'b1, 1'b1, 1'b0, 28'h000_0100, 8'h00);
    `CHK("ext_abt", 1'b1, cmd_result.error[ERR_ABT_BIT]);
    ext_hpa_set <= 1'b0;
    cmd(1'b1, 1'b1, 1'b0, 28'hfff_ffff, 8'h00);
    `CHK("over_abt", 1'b1, cmd_result.error[ERR_ABT_BIT]);
    // Command for the other drive must be ignored
    host.send({8'h00, 8'h00, 24'h00_0100, 8'hf0, CMD_SET_LIMIT}, 1'b1);
    repeat (3) begin
      @(posedge sys_clk);
      `CHK("other_drv", 1'b0, cmd_done);
    end
    for (int i = 1; i <= 4; i++) begin
      cmd(1'b0, 1'b1, 1'b0, 28'h000_0000, 8'(i));
      `CHK("sub_valid", 1'b1, sv);
      `CHK("sub_cmd", 3'(i), sc);
      if (i == 2) begin
        cmd(1'b1, 1'b1, 1'b0, 28'h000_0100, 8'h00);
        `CHK("lock_abt", 1'b1, cmd_result.error[ERR_ABT_BIT]);
      end
    end
    cmd(1'b1, 1'b1, 1'b0, 28'h000_0100, 8'h00);
    `CHK("frozen_abt", 1'b1, cmd_result.error[ERR_ABT_BIT]);
    cmd(1'b0, 1'b1, 1'b0, 28'h000_0000, 8'h05);
    `CHK("bad_sub", 1'b0, sv);
    end_of_test();
  end
endmodule // tb

//--- rtl/sml_limit_cmd.sv
// Address-limit command interpreter with Wishbone register access
// Function
// [R1] Command F9h replaces max address when the request fits the capacity.
// [R2] Accesses beyond the set limit are refused with the abort flag.
// [R3] Both identify commands report the new limit as default maximum.
// [R4] After read-native-max the command sets the limit whatever Feature holds.
// [R5] Otherwise Feature picks subcommand: password, lock, unlock, freeze.
// [R6] Host should issue read-native-max and wait before this command.
// [R7] Locked or frozen limit security state aborts the limit command.
// [R8] CHS takes cylinder from LBA High/Mid; head and LBA Low default.
// [R9] LBA assembles Low 0-7, Mid 8-15, High 16-23, head 24-27.
// [R10] On success identify words 61:60 hold the new maximum.
// [R11] Words 103:100 follow 61:60 except the 28-bit ceiling case.
// [R12] A protected area set by the extended command aborts this one.
// [R13] Option bit one keeps the limit over resets; zero loses it. Here rst_b loads all ones whatever the option.
// [R14] Nonvolatile option in address-offset mode aborts the command.
// [R15] The limit form ignores the Feature register.
// [R16] Device register L bit: zero CHS, one LBA.
// [R17] Device register D bit: zero master, one slave.
// [R18] Abort sets abort flag and error, clears busy, keeps ready.
`timescale 1ns/1ns
module sml_limit_cmd
  import sml_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX = 28'h0FF_FFFF,
  parameter logic [15:0] DEF_CYL_MAX = 16'h3FFF,
  parameter logic [3:0] DEF_HEADS = 4'hF,
  parameter logic [5:0] DEF_SECTORS = 6'h3F,
  parameter logic DRIVE_ID = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Hard reset pin, asynchronous
  input wire logic hard_reset_b,
  // Task-file command strobe from the host-side logic
  input wire logic cmd_valid,
  input wire sml_pkg::sml_taskfile_s cmd_tf,
  // Access check request
  input wire logic acc_valid,
  input wire logic [27:0] acc_lba,
  // Device state inputs
  input wire logic offset_mode,
  input wire logic ext_hpa_set,
  // Command result
  output sml_pkg::sml_result_s cmd_result,
  output logic cmd_done,
  output logic acc_abort,
  output logic [27:0] limit_out,
  output sml_pkg::sml_sub_e sub_cmd,
  output logic sub_valid,
  // Wishbone slave
  input wire sml_pkg::sml_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  // Interrupt
  output logic irq
);
  import sml_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Feature code to subcommand kind
  function automatic sml_sub_e sub_of(input logic [7:0] f);
    case (f)
      FEAT_PASSWORD: return SML_SUB_PASSWORD;
      FEAT_LOCK: return SML_SUB_LOCK;
      FEAT_UNLOCK: return SML_SUB_UNLOCK;
      FEAT_FREEZE: return SML_SUB_FREEZE;
      default: return SML_SUB_NONE;
    endcase
  endfunction

  logic hrst_s;
  logic hrst_d;
  logic native_seen;
  logic locked;
  logic frozen;
  logic nonvol;
  logic [27:0] limit;
  logic [27:0] id60;
  logic [47:0] id100;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [31:0] ctrl;

  sml_sync #(.W(1)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .d(hard_reset_b),
    .q(hrst_s)
  );

  // Hard reset falling edge
  wire hard_rst_ev = hrst_d && !hrst_s;
  // Command decode
  wire for_us = cmd_tf.device[DEV_DRV_BIT] == DRIVE_ID; // R17
  wire is_limit_cmd = cmd_valid && for_us && cmd_tf.command == CMD_SET_LIMIT;
  wire is_native = cmd_valid && for_us && cmd_tf.command == CMD_READ_NATIVE;
  wire limit_form = is_limit_cmd && native_seen; // R4 R15
  wire sub_form = is_limit_cmd && !native_seen; // R5
  wire sml_sub_e sub_kind = sub_of(cmd_tf.feature); // R5
  wire lba_mode = cmd_tf.device[DEV_LBA_BIT]; // R16
  wire opt_nv = cmd_tf.sect_cnt[SC_NONVOL_BIT];
  // Requested maximum in LBA units
  wire [27:0] req_lba = {cmd_tf.device[3:0], cmd_tf.lba_high, cmd_tf.lba_mid,
                         cmd_tf.lba_low}; // R9
  wire [15:0] req_cyl = {cmd_tf.lba_high, cmd_tf.lba_mid}; // R8
  wire [31:0] cyl_lba_w = ({16'h0000, req_cyl} + 32'h0000_0001) *
                          {24'h00_0000, 4'h0, DEF_HEADS} * 32'h0000_0001;
  wire [31:0] chs_cnt = cyl_lba_w * ({26'h000_0000, DEF_SECTORS} + 32'h0000_0001)
                        - 32'h0000_0001;
  wire [27:0] chs_lba = chs_cnt[27:0]; // R8
  wire [27:0] new_max = lba_mode ? req_lba : chs_lba;
  // Only a drive whose native maximum equals the 28-bit ceiling takes the ceiling request
  wire big_dev = NATIVE_MAX == LBA28_MAX[27:0];
  wire ceil_req = lba_mode && big_dev && (req_lba == LBA28_MAX[27:0]); // R11
  wire over_cap = !lba_mode ? (req_cyl > DEF_CYL_MAX) : (new_max > NATIVE_MAX); // R1
  wire lim_abort = locked || frozen || ext_hpa_set || (opt_nv && offset_mode)
                   || (over_cap && !ceil_req); // R7 R12 R14 R1
  wire feat_ok = cmd_tf.feature >= FEAT_PASSWORD && cmd_tf.feature <= FEAT_FREEZE;
  wire sub_abort = !feat_ok || frozen;
  wire cmd_abort = limit_form ? lim_abort : sub_abort;
  wire [27:0] eff_max = ceil_req ? NATIVE_MAX : new_max; // R11
  // Events
  wire ev_done = is_limit_cmd && !cmd_abort;
  wire ev_abort = is_limit_cmd && cmd_abort;
  wire ev_range = acc_valid && acc_lba > limit; // R2
  wire [EV_W-1:0] ev_vec = {ev_range, sub_form && !sub_abort, ev_abort, ev_done};
  // Wishbone decode
  wire wb_go = wb_req.cyc && wb_req.stb && !wb_ack;
  wire wb_wr = wb_go && wb_req.we && wb_req.sel[0];
  wire [EV_W-1:0] stat_clr = (wb_wr && hit(wb_req.adr, REG_IRQ_STAT))
                             ? wb_req.dat[EV_W-1:0] : '0;
  wire [31:0] rd_mux =
    hit(wb_req.adr, REG_CTRL) ? ctrl :
    hit(wb_req.adr, REG_STATUS) ? {26'h0, nonvol, frozen, locked, native_seen,
                                   cmd_result.error[ERR_ABT_BIT],
                                   cmd_result.status[ST_ERR_BIT]} :
    hit(wb_req.adr, REG_LIMIT) ? {4'h0, limit} :
    hit(wb_req.adr, REG_ID60) ? {4'h0, id60} :
    hit(wb_req.adr, REG_ID100) ? id100[31:0] :
    hit(wb_req.adr, REG_IRQ_STAT) ? {28'h0, irq_stat} :
    hit(wb_req.adr, REG_IRQ_MASK) ? {28'h0, irq_mask} :
    hit(wb_req.adr, REG_NATIVE) ? {4'h0, NATIVE_MAX} : 32'h0000_0000;
  // Software may force a volatile-limit drop via ctrl bit 0
  wire sw_drop = ctrl[0];
  wire vol_reset = (hard_rst_ev || sw_drop) && !nonvol; // R13
  // Accepted forms, shared by several registers below
  wire sub_ok = sub_form && !sub_abort; // R5
  wire lim_ok = limit_form && !lim_abort; // R1
  // Set wins over a write-one clear in the same cycle
  wire [EV_W-1:0] next_irq_stat = (irq_stat & ~stat_clr) | ev_vec;

  // Low after reset so the idle-high pin gives no false edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hrst_d <= 1'b0;
    end else begin
      hrst_d <= hrst_s;
    end
  end

  // One wait state: ack and read data one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack <= wb_go;
      wb_dat_o <= wb_go ? rd_mux : 32'h0000_0000;
    end
  end

  // Control word; bit 0 clears itself after one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
    end else if (wb_wr && hit(wb_req.adr, REG_CTRL)) begin
      ctrl <= wb_req.dat;
    end else begin
      ctrl <= {ctrl[31:1], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_mask <= MASK_RESET;
    end else if (wb_wr && hit(wb_req.adr, REG_IRQ_MASK)) begin
      irq_mask <= wb_req.dat[EV_W-1:0];
    end
  end

  // Interrupt follows the next status so it rises with the event
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // Registered pulses and the limit copy
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmd_done <= 1'b0;
      sub_valid <= 1'b0;
      acc_abort <= 1'b0;
      limit_out <= '1;
    end else begin
      cmd_done <= is_limit_cmd;
      sub_valid <= sub_ok; // R5
      acc_abort <= ev_range; // R2
      limit_out <= limit;
    end
  end

  // Any other command to this drive breaks the read-native pairing
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      native_seen <= 1'b0;
    end else if (hard_rst_ev) begin
      native_seen <= 1'b0;
    end else if (cmd_valid && for_us) begin
      native_seen <= is_native; // R4
    end
  end

  // Lock state; hard reset wins over a lock in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      locked <= 1'b0;
    end else if (hard_rst_ev) begin
      locked <= 1'b0;
    end else if (sub_ok && sub_kind == SML_SUB_LOCK) begin
      locked <= 1'b1;
    end else if (sub_ok && sub_kind == SML_SUB_UNLOCK) begin
      locked <= 1'b0;
    end
  end

  // Freeze holds until power-on reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      frozen <= 1'b0;
    end else if (sub_ok && sub_kind == SML_SUB_FREEZE) begin
      frozen <= 1'b1;
    end
  end

  // Nonvolatile limit survives hard reset and the ctrl bit 0 drop; power-on reset is rst_b
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      limit <= '1;
      nonvol <= 1'b0;
    end else if (vol_reset) begin
      limit <= NATIVE_MAX; // R13
    end else if (lim_ok) begin
      limit <= eff_max; // R1
      nonvol <= opt_nv; // R13
    end
  end

  // Identify words 61:60 and the low part of 103:100
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      id60 <= '1;
      id100 <= '1;
    end else if (vol_reset) begin
      id60 <= NATIVE_MAX;
      id100 <= {20'h0_0000, NATIVE_MAX};
    end else if (lim_ok) begin
      id60 <= ceil_req ? LBA28_MAX[27:0] : eff_max; // R3 R10 R11
      id100 <= {20'h0_0000, eff_max}; // R11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sub_cmd <= SML_SUB_NONE;
    end else if (sub_ok) begin
      sub_cmd <= sub_kind; // R5
    end
  end

  // Result stands until the next command of this kind
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmd_result <= '0;
    end else if (is_limit_cmd) begin
      cmd_result.error <= cmd_abort ? (8'h01 << ERR_ABT_BIT) : 8'h00; // R18
      cmd_result.status <= (8'h01 << ST_RDY_BIT) |
                           (cmd_abort ? (8'h01 << ST_ERR_BIT) : 8'h00); // R18
    end
  end
endmodule // sml_limit_cmd

//--- rtl/sml_pkg.sv
// Package for the address-limit command interpreter
package sml_pkg;
  // Command codes
  localparam logic [7:0] CMD_SET_LIMIT = 8'hF9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
  // Feature codes of the security subcommands
  localparam logic [7:0] FEAT_PASSWORD = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;
  // Device register fields
  localparam int DEV_LBA_BIT = 6;
  localparam int DEV_DRV_BIT = 4;
  // Sector count option bit
  localparam int SC_NONVOL_BIT = 0;
  // Error and status bit positions
  localparam int ERR_ABT_BIT = 2;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_ERR_BIT = 0;
  // 28-bit address ceiling
  localparam logic [47:0] LBA28_MAX = 48'h0000_0FFF_FFFF;
  // Wishbone register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LIMIT = 8'h08;
  localparam logic [7:0] REG_ID60 = 8'h0C;
  localparam logic [7:0] REG_ID100 = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_NATIVE = 8'h1C;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Interrupt event bits
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_SUBCMD = 2;
  localparam int EV_RANGE = 3;
  localparam int EV_W = 4;

  typedef enum logic [2:0] {
    SML_SUB_NONE, SML_SUB_PASSWORD, SML_SUB_LOCK, SML_SUB_UNLOCK, SML_SUB_FREEZE
  } sml_sub_e;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sect_cnt;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] device;
    logic [7:0] command;
  } sml_taskfile_s;

  typedef struct packed {
    logic [7:0] error;
    logic [7:0] status;
  } sml_result_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sml_wb_req_s;
endpackage

//--- rtl/sml_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ns
module sml_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sml_sync
